/* File: inc/pax_defines.vh */
// constants for the autoneg expansion / mirror / interrupt register block
`ifndef PAX_DEFINES_VH
`define PAX_DEFINES_VH

// =====================================================================
// register addresses on the management port
`define PAX_REG_CTRL_STAT 5'h01
`define PAX_REG_EXPANSION 5'h06
`define PAX_REG_MIRROR 5'h10
`define PAX_REG_INT_LINK 5'h11
`define PAX_REG_INT_STAT 5'h12

// =====================================================================
// field positions
`define PAX_EXP_LP_AN_ABLE 0
`define PAX_EXP_PAGE_RCVD 1
`define PAX_EXP_NP_ABLE 2
`define PAX_EXP_LP_NP_ABLE 3
`define PAX_EXP_PAR_FAULT 4
`define PAX_CTL_TEST_INT 0
`define PAX_CTL_INT_EN 1
`define PAX_CTL_LINK_RULE 2
`define PAX_CTL_DRIVE_LVL 3
`define PAX_INT_STAT_PEND 15

// =====================================================================
// reset values
`define PAX_MIRROR_RST 16'h0000
`define PAX_CTL_RST 4'h0

// =====================================================================
// management frame figures
`define PAX_OP_READ 2'h2
`define PAX_OP_WRITE 2'h1
`define PAX_PREAMBLE_BITS 6'h20
`define PAX_HDR_LAST 4'hB
`define PAX_DATA_BITS 5'h10
`define PAX_SAME_WORDS 2'h3

// =====================================================================
// timing, in cycles of the 50 MHz device clock
// lock loss: 1 ms; data line interrupt pulse: 320 ns
`define PAX_LOCK_LOSS_CYC 17'h0C350
`define PAX_MDIO_PULSE_CYC 5'h10

`endif

/* File: rtl/pax_regs.v */
// management register block: autoneg expansion, mirror, interrupt control
`timescale 1ns/1ps
`include "pax_defines.vh"

module pax_regs #(
    parameter [4:0] PHY_ADDR = 5'h00,
    parameter [16:0] LOCK_LOSS_CYCLES = `PAX_LOCK_LOSS_CYC
) (
    input wire CLOCK_I,
    input wire RST_N_I,
    input wire MDC_I,
    input wire MDIO_I,
    output reg MDIO_O,
    output reg MDIO_OE_O,
    input wire PAR_DET_FAULT_I,
    input wire LP_NEXT_PAGE_ABLE_I,
    input wire LP_AUTONEG_ABLE_I,
    input wire CODE_WORD_VALID_I,
    input wire [15:0] CODE_WORD_I,
    input wire SCRAMBLER_LOCKED_I,
    input wire SER_LINK_OK_I,
    input wire MDIO_INT_ENABLE_I,
    output reg MANAGEMENT_INTERRUPT_OUT_N_O,
    output reg INTERRUPT_PENDING_FLAG_O,
    output reg OUTPUT_DRIVE_STRENGTH_SELECT_O,
    output reg LINK_UP_O
);

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_HDR = 5'h02;
    localparam [4:0] ST_TA = 5'h04;
    localparam [4:0] ST_RD = 5'h08;
    localparam [4:0] ST_WR = 5'h10;
    localparam [4:0] PULSE_CYC = `PAX_MDIO_PULSE_CYC;

    // =================================================================
    // read data for an address, zero where nothing is mapped
    function [15:0] read_word;
        input [4:0] addr;
        input [1:0] lh_bits;
        input lp_np;
        input lp_an;
        input [15:0] mirror;
        input [3:0] ctl;
        input pend;
        begin
            read_word = 16'h0000;
            case (addr)
                `PAX_REG_EXPANSION: begin
                    read_word[`PAX_EXP_PAR_FAULT] = lh_bits[1];
                    read_word[`PAX_EXP_LP_NP_ABLE] = lp_np;
                    read_word[`PAX_EXP_PAGE_RCVD] = lh_bits[0];
                    read_word[`PAX_EXP_LP_AN_ABLE] = lp_an;
                end
                `PAX_REG_MIRROR: read_word = mirror;
                `PAX_REG_INT_LINK: read_word[3:0] = ctl;
                `PAX_REG_INT_STAT: read_word[`PAX_INT_STAT_PEND] = pend;
                default: read_word = 16'h0000;
            endcase
        end
    endfunction

    reg mdc_s1_reg;
    reg mdc_s2_reg;
    reg mdc_d_reg;
    reg mdio_s1_reg;
    reg mdio_s2_reg;
    reg [4:0] state_reg;
    reg [5:0] pre_cnt_reg;
    reg start_ok_reg;
    reg [4:0] bit_cnt_reg;
    reg [11:0] hdr_reg;
    reg rd_op_reg;
    reg [4:0] addr_reg;
    reg [15:0] shift_reg;
    reg [15:0] mirror_reg;
    reg [3:0] ctl_reg;
    reg fault_lh_reg;
    reg page_lh_reg;
    reg read_one_armed_reg;
    reg [15:0] last_word_reg;
    reg [1:0] same_cnt_reg;
    reg [16:0] lock_timer_reg;
    reg int_active_d_reg;
    reg [4:0] pulse_cnt_reg;

    wire mdc_rise = mdc_s2_reg & ~mdc_d_reg;
    wire bit_in = mdio_s2_reg;
    wire [11:0] hdr_full = {hdr_reg[10:0], bit_in};
    wire hdr_done = (state_reg == ST_HDR) && mdc_rise
        && (bit_cnt_reg[3:0] == `PAX_HDR_LAST);
    wire hdr_match = hdr_full[9:5] == PHY_ADDR;
    wire hdr_read = hdr_done && hdr_match
        && (hdr_full[11:10] == `PAX_OP_READ);
    wire hdr_write = hdr_done && hdr_match
        && (hdr_full[11:10] == `PAX_OP_WRITE);
    wire wr_done = (state_reg == ST_WR) && mdc_rise
        && (bit_cnt_reg == `PAX_DATA_BITS - 5'h01);
    wire [4:0] rd_addr = hdr_full[4:0];
    wire rd_exp = hdr_read && (rd_addr == `PAX_REG_EXPANSION);
    wire int_en = ctl_reg[`PAX_CTL_INT_EN];
    // the force bit only counts under the master enable
    wire int_active = int_en & ctl_reg[`PAX_CTL_TEST_INT];
    wire page_event = CODE_WORD_VALID_I && (CODE_WORD_I == last_word_reg)
        && (same_cnt_reg == `PAX_SAME_WORDS - 2'h1);
    wire lock_lost = lock_timer_reg >= LOCK_LOSS_CYCLES;

    // =================================================================
    // pin synchronisers, two flops each before any logic looks
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mdc_s1_reg <= 1'b0;
            mdc_s2_reg <= 1'b0;
            mdc_d_reg <= 1'b0;
            mdio_s1_reg <= 1'b1;
            mdio_s2_reg <= 1'b1;
        end else begin
            mdc_s1_reg <= MDC_I;
            mdc_s2_reg <= mdc_s1_reg;
            mdc_d_reg <= mdc_s2_reg;
            mdio_s1_reg <= MDIO_I;
            mdio_s2_reg <= mdio_s1_reg;
        end
    end

    // =================================================================
    // management frame engine, one step per mdc rising edge
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_IDLE;
            pre_cnt_reg <= 6'h00;
            start_ok_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
            hdr_reg <= 12'h000;
            rd_op_reg <= 1'b0;
            addr_reg <= 5'h00;
            shift_reg <= 16'h0000;
            MDIO_O <= 1'b1;
            MDIO_OE_O <= 1'b0;
            pulse_cnt_reg <= 5'h00;
            int_active_d_reg <= 1'b0;
        end else begin
            int_active_d_reg <= int_active;
            // interrupt pulse on an idle line, on a fresh interrupt
            if (state_reg == ST_IDLE && pre_cnt_reg == 6'h00
                && int_active && !int_active_d_reg
                && MDIO_INT_ENABLE_I) begin
                pulse_cnt_reg <= PULSE_CYC;
                MDIO_O <= 1'b0;
                MDIO_OE_O <= 1'b1;
            end else if (pulse_cnt_reg != 5'h00) begin
                pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
                if (pulse_cnt_reg == 5'h01) begin
                    MDIO_OE_O <= 1'b0;
                    MDIO_O <= 1'b1;
                end
            end
            if (mdc_rise) begin
                case (state_reg)
                    ST_IDLE: begin
                        if (start_ok_reg) begin
                            start_ok_reg <= 1'b0;
                            pre_cnt_reg <= 6'h00;
                            bit_cnt_reg <= 5'h00;
                            if (bit_in) begin
                                state_reg <= ST_HDR;
                            end
                        end else if (bit_in) begin
                            if (pre_cnt_reg != `PAX_PREAMBLE_BITS) begin
                                pre_cnt_reg <= pre_cnt_reg + 6'h01;
                            end
                        end else begin
                            // a zero after a full preamble opens start
                            start_ok_reg <=
                                pre_cnt_reg == `PAX_PREAMBLE_BITS;
                            pre_cnt_reg <= 6'h00;
                        end
                    end
                    ST_HDR: begin
                        hdr_reg <= hdr_full;
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (hdr_done) begin
                            bit_cnt_reg <= 5'h00;
                            addr_reg <= rd_addr;
                            rd_op_reg <= hdr_read;
                            // sample the word as it stands when addressed
                            shift_reg <= read_word(rd_addr,
                                {fault_lh_reg, page_lh_reg},
                                LP_NEXT_PAGE_ABLE_I, LP_AUTONEG_ABLE_I,
                                mirror_reg, ctl_reg,
                                INTERRUPT_PENDING_FLAG_O);
                            state_reg <= (hdr_read | hdr_write) ?
                                ST_TA : ST_IDLE;
                        end
                    end
                    ST_TA: begin
                        // first turnaround bit passed; drive the zero
                        if (rd_op_reg) begin
                            pulse_cnt_reg <= 5'h00;
                            MDIO_O <= 1'b0;
                            MDIO_OE_O <= 1'b1;
                            state_reg <= ST_RD;
                        end else begin
                            state_reg <= ST_WR;
                            bit_cnt_reg <= 5'h1F;
                        end
                    end
                    ST_RD: begin
                        if (bit_cnt_reg == `PAX_DATA_BITS) begin
                            MDIO_OE_O <= 1'b0;
                            MDIO_O <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            MDIO_O <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                    ST_WR: begin
                        // count starts at all ones to skip turnaround
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg != 5'h1F) begin
                            shift_reg <= {shift_reg[14:0], bit_in};
                        end
                        if (wr_done) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // =================================================================
    // writable registers; upper bits of 17 are not stored
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mirror_reg <= `PAX_MIRROR_RST;
            ctl_reg <= `PAX_CTL_RST;
        end else if (wr_done) begin
            if (addr_reg == `PAX_REG_MIRROR) begin
                mirror_reg <= {shift_reg[14:0], bit_in};
            end
            if (addr_reg == `PAX_REG_INT_LINK) begin
                ctl_reg <= {shift_reg[2:0], bit_in};
            end
        end
    end

    // =================================================================
    // latched status; an event in the read cycle survives the clear
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fault_lh_reg <= 1'b0;
            page_lh_reg <= 1'b0;
            last_word_reg <= 16'h0000;
            same_cnt_reg <= 2'h0;
        end else begin
            fault_lh_reg <= PAR_DET_FAULT_I
                | (fault_lh_reg & ~rd_exp);
            page_lh_reg <= page_event | (page_lh_reg & ~rd_exp);
            if (CODE_WORD_VALID_I) begin
                last_word_reg <= CODE_WORD_I;
                if (CODE_WORD_I != last_word_reg) begin
                    same_cnt_reg <= 2'h1;
                end else if (same_cnt_reg != `PAX_SAME_WORDS) begin
                    same_cnt_reg <= same_cnt_reg + 2'h1;
                end
            end
        end
    end

    // =================================================================
    // interrupt pin follows the interrupt; pending flag cleared by read 1 then read 18
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            read_one_armed_reg <= 1'b0;
            INTERRUPT_PENDING_FLAG_O <= 1'b0;
            MANAGEMENT_INTERRUPT_OUT_N_O <= 1'b1;
        end else begin
            MANAGEMENT_INTERRUPT_OUT_N_O <= ~int_active;
            if (hdr_read) begin
                read_one_armed_reg <= rd_addr == `PAX_REG_CTRL_STAT;
            end
            // set wins over the clear
            if (int_active) begin
                INTERRUPT_PENDING_FLAG_O <= 1'b1;
            end else if (hdr_read && read_one_armed_reg
                && rd_addr == `PAX_REG_INT_STAT) begin
                INTERRUPT_PENDING_FLAG_O <= 1'b0;
            end
        end
    end

    // =================================================================
    // drive strength and link decision
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            OUTPUT_DRIVE_STRENGTH_SELECT_O <= 1'b0;
            lock_timer_reg <= 17'h00000;
            LINK_UP_O <= 1'b0;
        end else begin
            OUTPUT_DRIVE_STRENGTH_SELECT_O <=
                ctl_reg[`PAX_CTL_DRIVE_LVL];
            if (SCRAMBLER_LOCKED_I) begin
                lock_timer_reg <= 17'h00000;
            end else if (!lock_lost) begin
                lock_timer_reg <= lock_timer_reg + 17'h00001;
            end
            if (ctl_reg[`PAX_CTL_LINK_RULE]) begin
                // enhanced: up from error rate, down from lock loss
                if (lock_lost) begin
                    LINK_UP_O <= 1'b0;
                end else if (SER_LINK_OK_I) begin
                    LINK_UP_O <= 1'b1;
                end
            end else begin
                LINK_UP_O <= SER_LINK_OK_I;
            end
        end
    end

endmodule // pax_regs

/* File: bench/pax_mdio_host.sv */
// station management controller model driving the serial management port
`timescale 1ns/1ps
module pax_mdio_host #(
    parameter [4:0] PHY_ADDR = 5'h00
) (
    output logic mdc_o,
    output logic mdio_oe_o,
    output logic mdio_d_o,
    input wire logic mdio_i
);
    // =====================================================
    // link clock stands low and the line is released between frames
    initial begin
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
        mdio_d_o = 1'b1;
    end

    // one 160 ns period: set in the low phase, sample at the rise
    task automatic bit_cyc(input logic oe, input logic d, output logic s);
        mdio_oe_o = oe;
        mdio_d_o = d;
        #80;
        mdc_o = 1'b1;
        s = mdio_i;
        #80;
        mdc_o = 1'b0;
    endtask

    // full frame; a fresh 32-bit preamble every time, read data msb first
    task automatic xfer(input logic wr, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hdr;
        logic s;
        integer i;
        hdr = {32'hFFFFFFFF, 2'b01, (wr ? 2'b01 : 2'b10), PHY_ADDR, ra};
        for (i = 45; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
        rd = 16'h0000;
        // turnaround then data; on reads the line is left to the device
        for (i = 0; i < 18; i++) begin
            if (wr) bit_cyc(1'b1, i == 0 || (i >= 2 && wd[17 - i]), s);
            else bit_cyc(1'b0, 1'b1, s);
            if (!wr && i >= 2) rd[17 - i] = s;
        end
        mdio_oe_o = 1'b0;
    endtask
endmodule // pax_mdio_host

/* File: bench/pax_regs_properties.sv */
// concurrent checks on the ports of the management register block
`timescale 1ns/1ps
module pax_regs_properties #(
    parameter [4:0] PHY_ADDR = 5'h00,
    parameter [16:0] LOCK_LOSS_CYCLES = 17'd50000
) (
    input wire CLOCK_I, input wire RST_N_I, input wire MDC_I,
    input wire MDIO_I, input wire MDIO_O, input wire MDIO_OE_O,
    input wire PAR_DET_FAULT_I, input wire LP_NEXT_PAGE_ABLE_I,
    input wire LP_AUTONEG_ABLE_I, input wire CODE_WORD_VALID_I,
    input wire [15:0] CODE_WORD_I, input wire SCRAMBLER_LOCKED_I,
    input wire SER_LINK_OK_I, input wire MDIO_INT_ENABLE_I,
    input wire MANAGEMENT_INTERRUPT_OUT_N_O,
    input wire INTERRUPT_PENDING_FLAG_O,
    input wire OUTPUT_DRIVE_STRENGTH_SELECT_O, input wire LINK_UP_O
);
    // =====================================================
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    // the shortest drive, the interrupt pulse, spans 16 clocks
    sequence oe_held16;
        MDIO_OE_O [*8] ##1 MDIO_OE_O [*8];
    endsequence
    sequence pin_low;
        !MANAGEMENT_INTERRUPT_OUT_N_O;
    endsequence

    oe_hold_a: assert property ($rose(MDIO_OE_O) |-> oe_held16)
        else $error("data line drive ended early");
    oe_first_low_a: assert property ($rose(MDIO_OE_O) |-> !MDIO_O)
        else $error("data line drive did not start low");
    oe_cause_a: assert property ($rose(MDIO_OE_O) |->
        MDIO_INT_ENABLE_I || $past(MDC_I, 2))
        else $error("data line driven with no cause");
    pin_pend_a: assert property (pin_low |-> ##[0:1]
        INTERRUPT_PENDING_FLAG_O)
        else $error("interrupt pin low without pending flag");
    pend_pin_a: assert property ($rose(INTERRUPT_PENDING_FLAG_O) |->
        ##[0:1] pin_low)
        else $error("pending flag set without interrupt pin");
    link_up_a: assert property ($rose(LINK_UP_O) |->
        $past(SER_LINK_OK_I))
        else $error("link came up with poor symbol rate");
    link_down_a: assert property ($fell(LINK_UP_O) |->
        !$past(SER_LINK_OK_I) || !$past(SCRAMBLER_LOCKED_I))
        else $error("link dropped with no cause");
    start_quiet_a: assert property ($rose(RST_N_I) |->
        MANAGEMENT_INTERRUPT_OUT_N_O && !INTERRUPT_PENDING_FLAG_O &&
        !MDIO_OE_O && !OUTPUT_DRIVE_STRENGTH_SELECT_O)
        else $error("outputs not quiet after reset");
endmodule // pax_regs_properties

bind pax_regs pax_regs_properties #(.PHY_ADDR(PHY_ADDR),
    .LOCK_LOSS_CYCLES(LOCK_LOSS_CYCLES)) u_props (
    .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .MDC_I(MDC_I),
    .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O),
    .PAR_DET_FAULT_I(PAR_DET_FAULT_I),
    .LP_NEXT_PAGE_ABLE_I(LP_NEXT_PAGE_ABLE_I),
    .LP_AUTONEG_ABLE_I(LP_AUTONEG_ABLE_I),
    .CODE_WORD_VALID_I(CODE_WORD_VALID_I), .CODE_WORD_I(CODE_WORD_I),
    .SCRAMBLER_LOCKED_I(SCRAMBLER_LOCKED_I),
    .SER_LINK_OK_I(SER_LINK_OK_I), .MDIO_INT_ENABLE_I(MDIO_INT_ENABLE_I),
    .MANAGEMENT_INTERRUPT_OUT_N_O(MANAGEMENT_INTERRUPT_OUT_N_O),
    .INTERRUPT_PENDING_FLAG_O(INTERRUPT_PENDING_FLAG_O),
    .OUTPUT_DRIVE_STRENGTH_SELECT_O(OUTPUT_DRIVE_STRENGTH_SELECT_O),
    .LINK_UP_O(LINK_UP_O));

/* File: bench/tb_top.sv */
// self-checking bench for the management register block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic clk, rst_n, mdc, hoe, hd, mdio_o, mdio_oe, par, lpnp, lpan, cwv;
    logic lock, ser_ok, mie, int_n, pend, drv, link, f, pr;
    logic [15:0] cw, v, r;
    logic [3:0] c;
    integer seed, i, tests_run, bad_count, base;
    integer low_cnt = 0;
    integer cyc = 0;
    wire line = mdio_oe ? mdio_o : (hoe ? hd : 1'b1); // pull-up if released

    pax_regs #(.LOCK_LOSS_CYCLES(17'd20)) u_dut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .MDC_I(mdc), .MDIO_I(line),
        .MDIO_O(mdio_o), .MDIO_OE_O(mdio_oe), .PAR_DET_FAULT_I(par),
        .LP_NEXT_PAGE_ABLE_I(lpnp), .LP_AUTONEG_ABLE_I(lpan),
        .CODE_WORD_VALID_I(cwv), .CODE_WORD_I(cw),
        .SCRAMBLER_LOCKED_I(lock), .SER_LINK_OK_I(ser_ok),
        .MDIO_INT_ENABLE_I(mie), .MANAGEMENT_INTERRUPT_OUT_N_O(int_n),
        .INTERRUPT_PENDING_FLAG_O(pend),
        .OUTPUT_DRIVE_STRENGTH_SELECT_O(drv), .LINK_UP_O(link));
    pax_mdio_host u_host (.mdc_o(mdc), .mdio_oe_o(hoe), .mdio_d_o(hd),
        .mdio_i(line));

    // =====================================================
    // clock, cycle ceiling and pulse-length counter
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (mdio_oe === 1'b1 && mdio_o === 1'b0) low_cnt <= low_cnt + 1;
        if (cyc == 80000) begin
            bad_count++;
            end_sim();
        end
    end

    // =====================================================
    // helpers; inputs always move 1 ns after the edge
    task automatic step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        u_host.xfer(1'b1, a, d, x);
        step(4);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        u_host.xfer(1'b0, a, 16'h0000, d);
        step(1);
    endtask
    task automatic cword(input logic [15:0] w);
        cw = w;
        cwv = 1'b1;
        step(1);
        cwv = 1'b0;
        step(1);
    endtask
    function automatic logic [15:0] exp6(input logic pf, input logic np,
                                         input logic pg, input logic an);
        exp6 = {11'h000, pf, np, 1'b0, pg, an};
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // =====================================================
    // main sequence
    initial begin
        seed = 89422;
        tests_run = 0;
        bad_count = 0;
        {rst_n, par, lpnp, lpan, cwv, ser_ok, mie} = 7'h00;
        lock = 1'b1;
        cw = 16'h0000;
        step(12);
        rst_n = 1'b1;
        step(3);
        rd(5'h06, r); `CHK(r, 16'h0000)
        rd(5'h10, r); `CHK(r, 16'h0000)
        rd(5'h11, r); `CHK(r, 16'h0000)
        rd(5'h1F, r); `CHK(r, 16'h0000)
        // random scratch and control words
        for (i = 0; i < 6; i++) begin
            v = $random(seed);
            c = v[3:0];
            wr(5'h10, v); rd(5'h10, r); `CHK(r, v)
            wr(5'h11, {12'h000, c});
            rd(5'h11, r); `CHK(r & 16'h000F, {12'h000, c})
            `CHK(drv, c[3])
            `CHK(int_n, ~(c[1] & c[0]))
        end
        // latched expansion bits, page seen only on three equal words
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            {pr, f, lpan, lpnp} = v[3:0];
            par = f;
            step(1);
            par = 1'b0;
            cword(v); cword(v); cword(pr ? v : ~v);
            rd(5'h06, r); `CHK(r, exp6(f, lpnp, pr, lpan))
            rd(5'h06, r); `CHK(r, exp6(1'b0, lpnp, 1'b0, lpan))
        end
        // pending flag survives a lone status read
        wr(5'h11, 16'h0003); `CHK(int_n, 1'b0)
        `CHK(pend, 1'b1)
        wr(5'h11, 16'h0002); `CHK(int_n, 1'b1)
        rd(5'h12, r); `CHK(r[15], 1'b1)
        `CHK(pend, 1'b1)
        rd(5'h01, r); rd(5'h12, r); `CHK(pend, 1'b0)
        // pulse on the data line only when everything enables it
        mie = 1'b1;
        wr(5'h11, 16'h0000); base = low_cnt;
        wr(5'h11, 16'h0003); step(30); `CHK(low_cnt - base, 16)
        wr(5'h11, 16'h0000); base = low_cnt;
        wr(5'h11, 16'h0001); step(30); `CHK(low_cnt - base, 0)
        wr(5'h11, 16'h0000); mie = 1'b0; base = low_cnt;
        wr(5'h11, 16'h0003); step(30); `CHK(low_cnt - base, 0)
        // link rules: lock loss only counts under the enhanced rule
        ser_ok = 1'b1;
        wr(5'h11, 16'h0004); step(3); `CHK(link, 1'b1)
        lock = 1'b0;
        step(15); `CHK(link, 1'b1)
        step(10); `CHK(link, 1'b0)
        lock = 1'b1;
        step(3); `CHK(link, 1'b1)
        wr(5'h11, 16'h0000); lock = 1'b0;
        step(30); `CHK(link, 1'b1)
        ser_ok = 1'b0;
        step(3); `CHK(link, 1'b0)
        ser_ok = 1'b1;
        step(3); `CHK(link, 1'b1)
        end_sim();
    end
endmodule // tb_top
